// ===== hw/standby_pkg.sv
// standby and reset sequencer: shared constants, states and the state record
// assumes a single 32-bit apb slave and one system clock
package standby_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_KEY_LO = 8'h04;
  localparam logic [7:0] ADDR_KEY_HI = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  // ==========================================================
  // control register fields
  localparam int CTRL_SLEEP_BIT = 0;
  localparam int CTRL_PCE_BIT = 1;
  localparam int CTRL_SEL_LSB = 2;
  // ==========================================================
  // values after reset
  localparam logic RST_PCE = 1'b1;
  localparam logic [2:0] RST_SEL = 3'h0;
  localparam logic [7:0] RST_KEY = 8'h00;
  // ==========================================================
  // prescaler and interval timer
  localparam int PRESC_W = 12;
  localparam int TIMER_W = 8;
  localparam int TAP10 = 10;
  localparam logic [2:0] SEL_TAP10 = 3'h7;
  localparam logic [3:0] TAP_BASE = 4'h3;
  localparam logic [7:0] TIMER_TOP = 8'hff;
  // ==========================================================
  // sequencer states
  typedef enum logic [2:0] {
    ST_RST,
    ST_POR,
    ST_RUN,
    ST_SLEEP,
    ST_STOP,
    ST_STAB,
    ST_LOWV
  } seq_state_t;
  // whole state of the sequencer, registered in one place
  typedef struct packed {
    seq_state_t state;
    logic [PRESC_W-1:0] presc;
    logic [TIMER_W-1:0] timer;
    logic rst_s1;
    logic rst_s2;
    logic lv_s1;
    logic lv_s2;
    logic [15:0] key_s1;
    logic [15:0] key_s2;
    logic [2:0] irq_a_s;
    logic [2:0] irq_b_s;
    logic periph_clock_enable;
    logic [2:0] interval_clock_select;
    logic [7:0] key_select_lo;
    logic [7:0] key_select_hi;
    logic stab_ok;
    logic vector_mode;
    logic resume;
    logic timer_irq;
    logic [3:0] wake_src;
    logic cpu_clk_en;
    logic periph_clk_en;
    logic osc_run;
    logic xout_high;
    logic xin_low;
    logic feedback_en;
    logic ports_input;
    logic core_reset_n;
    logic [PRESC_W-1:0] taps;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } seq_regs_t;
endpackage

// ===== hw/standby_reset_sequencer.sv
// standby and reset sequencer: sleep/stop entry, wake-up, power-on and pin reset,
// low-voltage mode. assumes apb master on pclk, core and interrupt controller
// on pclk, reset pin, key pins, external interrupt pins and lv detector async.
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - sleep bit stops cpu clock, oscillator runs
// - peripheral taps gateable, tap10 never gated
// - clock enable zero halts peripheral clocks
// - stop halts oscillator, all state kept
// - stop release waits timer, sets clock enable
// - reset, keys, pins wake both; timer sleep
// - low reset pin ends standby, reinitialises
// - low selected key pin releases standby
// - enabled external pin rising edge releases standby
// - global mask picks resume or vector
// - only individually enabled sources release standby
// - pending enabled interrupt blocks standby entry
// - prescaler and timer activity per state
// - stop drives xout high, xin low, feedback off
// - power-on reset lasts 256 tap10 ticks, just under 2^19 cycles
// - por clears counters, tap10 timer overflow ends it
// - low supply: ports input, stop release disabled
// - only reset leaves low-voltage mode
module standby_reset_sequencer
  import standby_pkg::*;
#(
  parameter int unsigned por_tap = TAP10 // lower only to shorten simulation
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic stop_exec,
  input wire logic irq_pending_any,
  input wire logic global_mask,
  input wire logic en_key,
  input wire logic en_irq_a,
  input wire logic en_irq_b,
  input wire logic en_timer,
  input wire logic reset_pin_n,
  input wire logic low_voltage,
  input wire logic [15:0] key_pin,
  input wire logic ext_irq_a,
  input wire logic ext_irq_b,
  output logic core_reset_n,
  output logic cpu_clk_en,
  output logic periph_clk_en,
  output logic [PRESC_W-1:0] periph_taps,
  output logic osc_run,
  output logic xout_high,
  output logic xin_low,
  output logic feedback_en,
  output logic ports_input,
  output logic resume,
  output logic vector_mode,
  output logic [3:0] wake_src,
  output logic timer_irq
);

  // ==========================================================
  // state record
  seq_regs_t st; // registered state
  seq_regs_t next_st; // next value

  // helper terms, from registered state and the core and apb inputs
  logic [PRESC_W-1:0] presc_inc; // prescaler plus one
  logic [3:0] tap_idx; // selected timer tap
  logic presc_runs; // prescaler advances this cycle
  logic timer_runs; // timer may count this cycle
  logic tick; // rising edge of selected tap
  logic ovf; // interval timer wraps
  logic key_hit; // selected key pin low
  logic a_rise; // enabled rising edge, pin a
  logic b_rise; // enabled rising edge, pin b
  logic tmr_wake; // timer overflow may wake sleep
  logic any_ext; // wake usable in sleep and stop
  logic wr_go; // apb write completes
  logic sleep_req; // sleep bit written

  // ==========================================================
  // wake and timer terms
  always_comb begin
    presc_inc = st.presc + 1'b1;
    // reset sequence forces the power-on tap
    if (st.state == ST_POR) begin
      tap_idx = 4'(por_tap);
    end else begin
      tap_idx = TAP_BASE + {1'b0, st.interval_clock_select};
    end
    // prescaler holds in stop, reset and low voltage
    presc_runs = (st.state == ST_RUN) || (st.state == ST_SLEEP) ||
                 (st.state == ST_STAB) || (st.state == ST_POR);
    // in sleep the timer only runs from tap10
    if (st.state == ST_SLEEP) begin
      timer_runs = (st.interval_clock_select == SEL_TAP10);
    end else begin
      timer_runs = presc_runs;
    end
    tick = presc_runs && timer_runs && presc_inc[tap_idx] && !st.presc[tap_idx];
    ovf = tick && (st.timer == TIMER_TOP);
    // only pins read through the second flop are looked at
    key_hit = en_key && |({st.key_select_hi, st.key_select_lo} & ~st.key_s2);
    a_rise = en_irq_a && st.irq_a_s[1] && !st.irq_a_s[2];
    b_rise = en_irq_b && st.irq_b_s[1] && !st.irq_b_s[2];
    // timer wake only from tap10, only out of sleep
    tmr_wake = en_timer && ovf && (st.interval_clock_select == SEL_TAP10);
    any_ext = key_hit || a_rise || b_rise;
    wr_go = psel && penable && st.pready && pwrite;
    sleep_req = wr_go && (paddr == ADDR_CTRL) && pwdata[CTRL_SLEEP_BIT];
  end

  // ==========================================================
  // next state
  always_comb begin
    next_st = st;
    // synchronisers: first stage feeds only the second
    next_st.rst_s1 = reset_pin_n;
    next_st.rst_s2 = st.rst_s1;
    next_st.lv_s1 = low_voltage;
    next_st.lv_s2 = st.lv_s1;
    next_st.key_s1 = key_pin;
    next_st.key_s2 = st.key_s1;
    next_st.irq_a_s = {st.irq_a_s[1:0], ext_irq_a};
    next_st.irq_b_s = {st.irq_b_s[1:0], ext_irq_b};
    next_st.resume = 1'b0;
    next_st.timer_irq = 1'b0;
    next_st.wake_src = 4'h0;
    // counters
    if (presc_runs) begin
      next_st.presc = presc_inc;
    end
    if (tick) begin
      next_st.timer = st.timer + 1'b1;
    end
    // register writes only while the core runs
    if (wr_go && (st.state == ST_RUN)) begin
      if (paddr == ADDR_CTRL) begin
        next_st.periph_clock_enable = pwdata[CTRL_PCE_BIT];
        next_st.interval_clock_select = pwdata[CTRL_SEL_LSB +: 3];
      end else if (paddr == ADDR_KEY_LO) begin
        next_st.key_select_lo = pwdata[7:0];
      end else if (paddr == ADDR_KEY_HI) begin
        next_st.key_select_hi = pwdata[7:0];
      end
    end
    // sequencer; pin reset has priority, then low supply
    if (!st.rst_s2) begin
      // pin reset: back to reset values from any state
      next_st.state = ST_RST;
      next_st.presc = '0;
      next_st.timer = '0;
      next_st.periph_clock_enable = RST_PCE;
      next_st.interval_clock_select = RST_SEL;
      next_st.key_select_lo = RST_KEY;
      next_st.key_select_hi = RST_KEY;
      next_st.vector_mode = 1'b0;
    end else if (st.lv_s2 && (st.state != ST_RST) && (st.state != ST_LOWV)) begin
      next_st.state = ST_LOWV;
    end else begin
      case (st.state)
        ST_RST: begin
          // pin released: run the normal reset timing
          next_st.state = ST_POR;
        end
        ST_POR: begin
          // ends on the first timer overflow
          if (ovf) begin
            next_st.state = ST_RUN;
            next_st.timer = '0;
          end
        end
        ST_RUN: begin
          if (ovf) begin
            next_st.timer_irq = 1'b1;
          end
          // a pending enabled request keeps the core awake
          if (irq_pending_any) begin
            next_st.state = ST_RUN;
          end else if (stop_exec) begin
            next_st.state = ST_STOP;
            // stop can only finish stabilising if the timer gets a clock
            next_st.stab_ok = (st.interval_clock_select == SEL_TAP10) ||
                              st.periph_clock_enable;
          end else if (sleep_req) begin
            next_st.state = ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (any_ext || tmr_wake) begin
            next_st.state = ST_RUN;
            next_st.resume = 1'b1;
            next_st.vector_mode = global_mask;
            next_st.wake_src = {tmr_wake, b_rise, a_rise, key_hit};
          end
        end
        ST_STOP: begin
          // without a stabilising clock only reset or low supply leaves stop
          if (any_ext && st.stab_ok) begin
            next_st.state = ST_STAB;
            next_st.timer = '0;
            next_st.vector_mode = global_mask;
            next_st.wake_src = {1'b0, b_rise, a_rise, key_hit};
          end
        end
        ST_STAB: begin
          // oscillator settle time is one timer wrap
          if (ovf) begin
            next_st.state = ST_RUN;
            next_st.periph_clock_enable = 1'b1;
            next_st.resume = 1'b1;
          end
        end
        ST_LOWV: begin
          // held here until the reset pin falls
          next_st.state = ST_LOWV;
        end
        default: begin
          next_st.state = ST_RST;
        end
      endcase
    end
    // outputs follow the state being entered
    next_st.core_reset_n = (next_st.state != ST_RST) && (next_st.state != ST_POR);
    next_st.cpu_clk_en = (next_st.state == ST_RUN);
    next_st.periph_clk_en = (next_st.state == ST_RUN) &&
                            next_st.periph_clock_enable;
    next_st.osc_run = (next_st.state != ST_STOP) && (next_st.state != ST_LOWV);
    next_st.xout_high = !next_st.osc_run;
    next_st.xin_low = !next_st.osc_run;
    next_st.feedback_en = next_st.osc_run;
    next_st.ports_input = (next_st.state == ST_LOWV) || (next_st.state == ST_RST);
    // peripheral taps: tap10 always passes while the prescaler counts
    next_st.taps = '0;
    if (next_st.periph_clock_enable) begin
      next_st.taps = next_st.presc;
    end
    next_st.taps[TAP10] = next_st.presc[TAP10];
    // apb: answer in the first access cycle, no wait states
    next_st.pready = psel && !penable;
    next_st.pslverr = 1'b0;
    next_st.prdata = '0;
    if (psel && !penable) begin
      if (paddr == ADDR_CTRL) begin
        next_st.prdata = {27'h0, st.interval_clock_select, st.periph_clock_enable, 1'b0};
      end else if (paddr == ADDR_KEY_LO) begin
        next_st.prdata = {24'h0, st.key_select_lo};
      end else if (paddr == ADDR_KEY_HI) begin
        next_st.prdata = {24'h0, st.key_select_hi};
      end else if (paddr == ADDR_STATUS) begin
        next_st.prdata = {11'h0, st.stab_ok, st.vector_mode, st.state,
                          st.timer, 4'h0, st.wake_src};
      end else begin
        next_st.pslverr = 1'b1; // unmapped address
      end
    end
  end

  // ==========================================================
  // state register; presetn acts as power-on detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.state <= ST_POR;
      st.periph_clock_enable <= RST_PCE;
      st.interval_clock_select <= RST_SEL;
      st.osc_run <= 1'b1;
      st.feedback_en <= 1'b1;
      st.rst_s1 <= 1'b1;
      st.rst_s2 <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs straight from flops
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign prdata = st.prdata;
  assign core_reset_n = st.core_reset_n;
  assign cpu_clk_en = st.cpu_clk_en;
  assign periph_clk_en = st.periph_clk_en;
  assign periph_taps = st.taps;
  assign osc_run = st.osc_run;
  assign xout_high = st.xout_high;
  assign xin_low = st.xin_low;
  assign feedback_en = st.feedback_en;
  assign ports_input = st.ports_input;
  assign resume = st.resume;
  assign vector_mode = st.vector_mode;
  assign wake_src = st.wake_src;
  assign timer_irq = st.timer_irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_sleep_entry: assert property (
    st.state == ST_RUN && sleep_req && !irq_pending_any && !stop_exec &&
    st.rst_s2 && !st.lv_s2 |=> st.state == ST_SLEEP ##1 !cpu_clk_en && osc_run)
    else $error("sleep not entered");
  a_pending_block: assert property (
    st.state == ST_RUN && irq_pending_any |=> st.state != ST_SLEEP && st.state != ST_STOP)
    else $error("standby entered with pending request");
  a_stop_pins: assert property (
    $rose(st.state == ST_STOP) |=> !osc_run && xout_high && xin_low && !feedback_en)
    else $error("oscillator pins wrong in stop");
  a_stab_enable: assert property (
    st.state == ST_STAB ##1 st.state == ST_RUN |=> periph_clk_en && resume == 1'b0)
    else $error("clock enable not set after stabilising");
  a_presc_hold: assert property (
    st.state == ST_STOP && $past(st.state) == ST_STOP |-> $stable(st.presc) && $stable(st.timer))
    else $error("counters moved in stop");
  a_tap10_free: assert property (
    st.state == ST_SLEEP [*2] |-> periph_taps[TAP10] == st.presc[TAP10] && st.presc != $past(st.presc))
    else $error("tap10 gated");
  a_lowv_hold: assert property (
    st.state == ST_LOWV && st.rst_s2 |=> st.state == ST_LOWV && ports_input)
    else $error("low voltage left without reset");
  a_pin_reset: assert property (
    !st.rst_s2 |=> st.state == ST_RST ##1 !core_reset_n)
    else $error("pin reset not taken");
  a_key_wake: assert property (
    st.state == ST_SLEEP && key_hit && st.rst_s2 && !st.lv_s2 |=> cpu_clk_en && resume)
    else $error("key did not wake sleep");
  a_stop_no_tmr: assert property (
    st.state == ST_STOP && !any_ext && st.rst_s2 && !st.lv_s2 |=> st.state == ST_STOP)
    else $error("stop left without external wake");

endmodule // standby_reset_sequencer

`default_nettype wire

// ===== bench/core_wake_model.sv
// partner model: processor core, interrupt controller and wake-up pins
// assumes the sequencer on pclk; the bench calls these tasks by hierarchy
`timescale 1ns/1ps
`default_nettype none
module core_wake_model (
  input wire logic pclk,
  output logic stop_exec,
  output logic irq_pending_any,
  output logic global_mask,
  output logic en_key,
  output logic en_irq_a,
  output logic en_irq_b,
  output logic en_timer,
  output logic reset_pin_n,
  output logic low_voltage,
  output logic [15:0] key_pin,
  output logic ext_irq_a,
  output logic ext_irq_b
);
  // ==========================================================
  // idle levels: keys and reset pin pulled up, irq lines low
  initial begin
    {stop_exec, irq_pending_any, global_mask, en_key} = 4'h0;
    {en_irq_a, en_irq_b, en_timer, low_voltage} = 4'h0;
    {reset_pin_n, key_pin, ext_irq_a, ext_irq_b} = {1'b1, 16'hffff, 2'b00};
  end
  // ==========================================================
  // pending, mask, key, a, b, timer enables from bit 5 down
  task automatic set_cfg(input logic [5:0] c);
    @(posedge pclk);
    {irq_pending_any, global_mask, en_key, en_irq_a, en_irq_b, en_timer} <= c;
  endtask
  // supply detector level
  task automatic set_lv(input logic v);
    @(posedge pclk);
    low_voltage <= v;
  endtask
  // stop lasts one cycle; the core then idles, as a nop would
  task automatic do_stop();
    @(posedge pclk);
    stop_exec <= 1'b1;
    @(posedge pclk);
    stop_exec <= 1'b0;
  endtask
  // three clocks low: margin over the two-cycle minimum
  task automatic pin_reset();
    @(posedge pclk);
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
  endtask
  // key held low, then back to the pull-up level
  task automatic key_press(input int i);
    @(posedge pclk);
    key_pin[i] <= 1'b0;
    repeat (6) @(posedge pclk);
    key_pin[i] <= 1'b1;
  endtask
  // rising edge on line b (b=1) or line a, held a few clocks
  task automatic irq_edge(input logic b);
    @(posedge pclk);
    {ext_irq_b, ext_irq_a} <= b ? 2'b10 : 2'b01;
    repeat (6) @(posedge pclk);
    {ext_irq_a, ext_irq_b} <= 2'b00;
  endtask
endmodule // core_wake_model
`default_nettype wire

// ===== bench/standby_reset_sequencer_tb_top.sv
// testbench: apb register access, standby entry and wake, reset paths
// assumes the core_wake_model partner drives all core and pin inputs
`timescale 1ns/1ps
`default_nettype none
module standby_reset_sequencer_tb_top;
  import standby_pkg::*;
  // ==========================================================
  // short power-on count keeps the run small
  localparam int POR_T = 2;
  localparam int POR_N = 1 << (POR_T + 9);
  localparam int STAB_N = 1 << (int'(TAP_BASE) + 9);
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rq;
  logic [4:0] wv; // wake source and mask taken while resume stands
  logic stop_exec, irq_pending_any, global_mask, en_key, en_irq_a, en_irq_b, en_timer;
  logic reset_pin_n, low_voltage, ext_irq_a, ext_irq_b, core_reset_n, cpu_clk_en;
  logic periph_clk_en, osc_run, xout_high, xin_low, feedback_en, ports_input;
  logic resume, vector_mode, timer_irq;
  logic [15:0] key_pin;
  logic [3:0] wake_src;
  logic [PRESC_W-1:0] periph_taps, ta, tz;
  int n_mismatch = 0;
  int comparisons = 0;
  int cycles = 0;
  int n;
  always #2 pclk = ~pclk;
  standby_reset_sequencer #(.por_tap(POR_T)) standby_reset_sequencer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .stop_exec(stop_exec), .irq_pending_any(irq_pending_any),
    .global_mask(global_mask), .en_key(en_key), .en_irq_a(en_irq_a), .en_irq_b(en_irq_b),
    .en_timer(en_timer), .reset_pin_n(reset_pin_n), .low_voltage(low_voltage), .key_pin(key_pin),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b), .core_reset_n(core_reset_n), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .periph_taps(periph_taps), .osc_run(osc_run), .xout_high(xout_high),
    .xin_low(xin_low), .feedback_en(feedback_en), .ports_input(ports_input), .resume(resume),
    .vector_mode(vector_mode), .wake_src(wake_src), .timer_irq(timer_irq));
  core_wake_model core_wake_model_i (.pclk(pclk), .stop_exec(stop_exec), .irq_pending_any(irq_pending_any),
    .global_mask(global_mask), .en_key(en_key), .en_irq_a(en_irq_a), .en_irq_b(en_irq_b),
    .en_timer(en_timer), .reset_pin_n(reset_pin_n), .low_voltage(low_voltage), .key_pin(key_pin),
    .ext_irq_a(ext_irq_a), .ext_irq_b(ext_irq_b));
  // ==========================================================
  // helpers
  task automatic final_report();
    $display("mismatches %0d, comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // apb transfer: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed: only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rq = prdata;
    {psel, penable} <= 2'b00;
  endtask
  function automatic logic [31:0] ctl(input logic [2:0] s, input logic p, input logic sl);
    return (32'(sl) << CTRL_SLEEP_BIT) | (32'(p) << CTRL_PCE_BIT) | (32'(s) << CTRL_SEL_LSB);
  endfunction
  task automatic por_chk();
    n = 0;
    // let the reset entry settle first: core_reset_n falls one edge late
    @(posedge pclk);
    while (core_reset_n !== 1'b1 && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(n >= POR_N - 16 && n <= POR_N + 24), 1);
  endtask
  task automatic wait_res(output int k);
    k = 0;
    while (resume !== 1'b1 && k < 6000) begin
      @(posedge pclk);
      k++;
    end
    // wake_src is a one-cycle pulse: take it at the resume edge
    wv = {wake_src, vector_mode};
  endtask
  // k: 0 selected key 3, 1 line a, 2 line b
  task automatic poke(input int k);
    if (k == 0) begin
      core_wake_model_i.key_press(3);
    end else begin
      core_wake_model_i.irq_edge(k == 2);
    end
  endtask
  task automatic no_wake(input int k);
    poke(k);
    cyc(4);
    chk(cpu_clk_en, 1'b0);
  endtask
  // sleep, try a disabled source kn (if any), then wake with k
  task automatic sleep_wake(input logic [5:0] c, input int kn, input int k, input logic [3:0] s, input logic vm);
    int m;
    core_wake_model_i.set_cfg(c);
    apb(1'b1, ADDR_CTRL, ctl(3'h0, 1'b1, 1'b1));
    cyc(3);
    chk({cpu_clk_en, osc_run}, 2'b01);
    if (kn >= 0) begin
      no_wake(kn);
    end
    fork
      poke(k);
      wait_res(m);
    join
    chk({m < 6000, wv}, {1'b1, s, vm});
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    por_chk();
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rq, ctl(RST_SEL, RST_PCE, 1'b0));
    apb(1'b0, ADDR_KEY_HI, 32'h0);
    chk(rq, 32'(RST_KEY));
    apb(1'b0, 8'h10, 32'h0);
    chk({pslverr, rq}, {1'b1, 32'h0});
    // peripheral clock off: only the tap10 output keeps toggling
    apb(1'b1, ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0));
    cyc(2);
    chk(periph_clk_en, 1'b0);
    ta = '0;
    tz = '1;
    n = 0;
    repeat (4200) begin
      @(posedge pclk);
      ta |= periph_taps;
      tz &= periph_taps;
      n += timer_irq;
    end
    chk(32'(ta ^ tz), 32'(1) << TAP10);
    chk(32'(n == 1 || n == 2), 1);
    apb(1'b1, ADDR_KEY_LO, 32'h08);
    core_wake_model_i.set_cfg(6'b101000);
    apb(1'b1, ADDR_CTRL, ctl(3'h0, 1'b1, 1'b1));
    cyc(3);
    chk(cpu_clk_en, 1'b1);
    sleep_wake(6'b001000, -1, 0, 4'h1, 1'b0);
    sleep_wake(6'b010100, 2, 1, 4'h2, 1'b1);
    sleep_wake(6'b000010, 0, 2, 4'h4, 1'b0);
    // timer wake: park the count at fe on tap3, then sleep on tap10
    core_wake_model_i.set_cfg(6'b010001);
    do begin
      apb(1'b0, ADDR_STATUS, 32'h0);
    end while (rq[15:8] !== 8'hfe);
    apb(1'b1, ADDR_CTRL, ctl(SEL_TAP10, 1'b1, 1'b1));
    wait_res(n);
    chk({n < 6000, wv}, {1'b1, 4'h8, 1'b1});
    apb(1'b1, ADDR_CTRL, ctl(3'h0, 1'b1, 1'b0));
    // stop with stabilisation through the tap3 timer
    core_wake_model_i.set_cfg(6'b010100);
    core_wake_model_i.do_stop();
    cyc(4);
    chk({osc_run, xout_high, xin_low, feedback_en, cpu_clk_en}, 5'b01100);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rq[18:16], 3'h4);
    fork
      core_wake_model_i.irq_edge(1'b0);
      wait_res(n);
    join
    chk(32'(n >= STAB_N - 20 && n <= STAB_N + 24), 1);
    cyc(2);
    chk(periph_clk_en, 1'b1);
    apb(1'b0, ADDR_KEY_LO, 32'h0);
    chk(rq, 32'h08);
    // stop with no timer clock: only the pin reset brings it back
    apb(1'b1, ADDR_CTRL, ctl(3'h0, 1'b0, 1'b0));
    core_wake_model_i.do_stop();
    no_wake(1);
    cyc(STAB_N + 200);
    chk(osc_run, 1'b0);
    core_wake_model_i.pin_reset();
    por_chk();
    apb(1'b0, ADDR_KEY_LO, 32'h0);
    chk(rq, 32'(RST_KEY));
    // low supply: ports input, keys ignored, only reset leaves
    apb(1'b1, ADDR_KEY_LO, 32'h08);
    core_wake_model_i.set_cfg(6'b001000);
    core_wake_model_i.set_lv(1'b1);
    cyc(5);
    chk({ports_input, osc_run}, 2'b10);
    no_wake(0);
    core_wake_model_i.set_lv(1'b0);
    cyc(10);
    chk(ports_input, 1'b1);
    core_wake_model_i.pin_reset();
    por_chk();
    chk(ports_input, 1'b0);
    final_report();
  end
endmodule // standby_reset_sequencer_tb_top
`default_nettype wire
